// *** psv_pkg.sv ***
// Constants and types shared by the program-space data access block.
// Assumes a 100 MHz instruction clock and a 24-bit program memory word.
package psv_pkg;

  // ------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------
  localparam logic [3:0]  OFS_TABLE_PAGE  = 4'h0;   // Table page register
  localparam logic [3:0]  OFS_VIS_PAGE    = 4'h1;   // Visibility page register
  localparam logic [3:0]  OFS_CORE_CTRL   = 4'h2;   // Core control register
  localparam logic [3:0]  OFS_STATUS      = 4'h3;   // Block status, read only
  localparam int          VIS_ENABLE_BIT  = 2;      // Visibility enable in core control
  localparam int          CFG_SPACE_BIT   = 7;      // Config space select in table page
  localparam logic [7:0]  RST_TABLE_PAGE  = 8'h00;
  localparam logic [7:0]  RST_VIS_PAGE    = 8'h00;
  localparam logic [15:0] RST_CORE_CTRL   = 16'h0000;

  // ------------------------------------------------------------
  // Self-programming granularity, in instructions
  // ------------------------------------------------------------
  localparam int          ROW_INSTR       = 64;     // 192 bytes
  localparam int          PAGE_INSTR      = 512;    // 1536 bytes
  localparam int          ADDR_PER_INSTR  = 2;      // Program address step per word
  localparam int          ROW_ADDR_BITS   = $clog2(ROW_INSTR * ADDR_PER_INSTR);
  localparam int          PAGE_ADDR_BITS  = $clog2(PAGE_INSTR * ADDR_PER_INSTR);

  // ------------------------------------------------------------
  // Extra stall cycles for visibility reads
  // ------------------------------------------------------------
  localparam logic [1:0]  EXTRA_MOVE      = 2'h1;   // Move or double move
  localparam logic [1:0]  EXTRA_OTHER     = 2'h2;   // Any other instruction
  localparam logic [1:0]  EXTRA_REP_EDGE  = 2'h2;   // Repeat loop edge iterations
  localparam logic [1:0]  EXTRA_REP_MID   = 2'h0;   // Repeat loop middle iterations

  // Access commands from the core
  typedef enum logic [2:0] {
    CMD_TABLE_READ_LOW,
    CMD_TABLE_READ_HIGH,
    CMD_TABLE_WRITE_LOW,
    CMD_TABLE_WRITE_HIGH,
    CMD_DATA_READ
  } cmd_t;

endpackage

// *** prog_addr_gen.sv ***
// Program address former for table and visibility accesses.
// Purely combinational; inputs come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module prog_addr_gen (
  input  wire logic [15:0] effective_address_in,  // Data effective address
  input  wire logic [7:0]  table_page_in,         // Table page value
  input  wire logic [7:0]  vis_page_in,           // Visibility page value
  input  wire logic        vis_enable_in,         // Visibility enable bit
  input  wire logic        table_busy_in,         // Table operation in progress
  input  wire logic        is_table_in,           // Access is a table operation
  output logic      [23:0] prog_addr_out,         // Formed program address
  output logic             config_space_out,      // Table access hits config space
  output logic             redirect_out,          // Data access goes to program memory
  output logic      [23:0] row_base_out,          // Base of enclosing write row
  output logic      [23:0] page_base_out          // Base of enclosing erase page
);
  import psv_pkg::*;

  // ------------------------------------------------------------
  // Address forming
  // ------------------------------------------------------------
  wire logic [23:0] table_addr;
  wire logic [23:0] vis_addr;

  // Page above the effective address
  assign table_addr       = {table_page_in, effective_address_in};
  // Page over low 15 bits, always user memory
  assign vis_addr         = {1'b0, vis_page_in, effective_address_in[14:0]};
  assign prog_addr_out    = is_table_in ? table_addr : vis_addr;
  assign config_space_out = is_table_in & table_page_in[CFG_SPACE_BIT];
  // Upper half of data space, only when no table op runs
  assign redirect_out     = effective_address_in[15] & vis_enable_in
                            & ~table_busy_in;

  // Row and page alignment for self-programming
  assign row_base_out  = {table_addr[23:ROW_ADDR_BITS], {ROW_ADDR_BITS{1'b0}}};
  assign page_base_out = {table_addr[23:PAGE_ADDR_BITS], {PAGE_ADDR_BITS{1'b0}}};

endmodule
`default_nettype wire

// *** psv_access.sv ***
// Program-space data access: table reads/writes and visibility reads.
// Assumes program memory returns read data the cycle after its read strobe,
// and that core requests arrive on the same clock as single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Word low-table read returns program bits 15..0 whole.
// - Byte low-table read picks upper byte when select is 1, else lower.
// - Word high-table read returns bits 23..16 low, upper data byte zero.
// - Byte high-table read gives bits 23..16 when select low, zero when high.
// - Table page bit 7 picks user memory (0) or configuration space (1).
// - Table address is table page above the 16-bit effective address.
// - Program address steps by two per word, matching data addresses.
// - Redirect only when address top bit and visibility enable are both set.
// - Visibility address is page above the low 15 address bits.
// - Data addresses from 8000h upward map into program memory.
// - Visibility accesses always target user memory, bit 23 zero.
// - Visibility read returns only the low 16 program bits.
// - Visibility reads stall one extra cycle for a second fetch.
// - Visibility is disabled while a table read or write runs.
// - Outside repeat: move adds one cycle, other instructions add two.
// - In repeat: edge iterations add two cycles, others run single cycle.
// - Self-programming writes words or 64-instruction rows, erases 512-instruction pages.
module psv_access (
  input  wire logic        sys_clk_in,          // 100 MHz instruction clock
  input  wire logic        nrst_in,             // Asynchronous reset, active low
  // Register port
  input  wire logic [3:0]  reg_addr_in,         // Register address
  input  wire logic [15:0] reg_wdata_in,        // Register write data
  input  wire logic        reg_wr_in,           // Write strobe
  input  wire logic        reg_rd_in,           // Read strobe
  output logic      [15:0] reg_rdata_out,       // Read data, cycle after strobe
  // Core access port
  input  wire logic        req_in,              // Access request pulse
  input  wire psv_pkg::cmd_t cmd_in,            // Access command
  input  wire logic        byte_mode_in,        // Byte rather than word access
  input  wire logic [15:0] effective_address_in, // Data effective address
  input  wire logic [15:0] wdata_in,            // Table write data
  input  wire logic        is_move_in,          // Move or double move instruction
  input  wire logic        in_repeat_in,        // Executing inside a repeat loop
  input  wire logic        repeat_edge_in,      // First/last/interrupt exit/re-entry
  output logic             redirect_out,        // Data access maps to program space
  output logic             stall_out,           // Core must wait
  output logic             done_out,            // Access complete pulse
  output logic      [15:0] rdata_out,           // Read data to core
  output logic      [23:0] row_base_out,        // Row base of table address
  output logic      [23:0] page_base_out,       // Page base of table address
  // Program memory port
  output logic      [23:0] pm_addr_out,         // Program address
  output logic             pm_rd_out,           // Program memory read strobe
  input  wire logic [23:0] pm_rdata_in,         // Program word, cycle after strobe
  output logic             pm_wr_out,           // Program latch write strobe
  output logic      [23:0] pm_wdata_out,        // Program write data
  output logic      [2:0]  pm_byte_en_out       // Byte lanes: upper, high, low
);
  import psv_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_FETCH2, ST_CAPTURE, ST_EXTRA, ST_WRITE}
    state_t;

  // ------------------------------------------------------------
  // Read data formatting
  // ------------------------------------------------------------
  function automatic logic [15:0] format_read(input cmd_t c, input logic bm,
                                              input logic bsel, input logic [23:0] w);
    logic [15:0] r;
    r = 16'h0000;
    if (c == CMD_TABLE_READ_LOW) begin
      if (!bm) r = w[15:0];
      else r = {8'h00, bsel ? w[15:8] : w[7:0]};
    end else if (c == CMD_TABLE_READ_HIGH) begin
      if (!bm) r = {8'h00, w[23:16]};
      else r = bsel ? 16'h0000 : {8'h00, w[23:16]};
    end else begin
      r = w[15:0];
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  // Two-stage release of the reset
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  table_page_reg;
  logic [7:0]  visibility_page_reg;
  logic        visibility_enable;
  logic [15:0] next_rdata;
  logic        last_config;
  state_t      state;
  state_t      next_state;

  wire logic [15:0] core_control_reg;
  wire logic [15:0] status_word;
  assign core_control_reg = {13'h0000, visibility_enable, 2'h0};
  assign status_word      = {8'h00, last_config, 4'h0, 3'(state)};

  // Read decode
  always_comb begin
    if (reg_addr_in == OFS_TABLE_PAGE) next_rdata = {8'h00, table_page_reg};
    else if (reg_addr_in == OFS_VIS_PAGE) next_rdata = {8'h00, visibility_page_reg};
    else if (reg_addr_in == OFS_CORE_CTRL) next_rdata = core_control_reg;
    else if (reg_addr_in == OFS_STATUS) next_rdata = status_word;
    else next_rdata = 16'h0000;
  end

  // Register writes and read data
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      table_page_reg      <= RST_TABLE_PAGE;
      visibility_page_reg <= RST_VIS_PAGE;
      visibility_enable   <= RST_CORE_CTRL[VIS_ENABLE_BIT];
      reg_rdata_out       <= 16'h0000;
    end else begin
      if (reg_wr_in && reg_addr_in == OFS_TABLE_PAGE) table_page_reg <= reg_wdata_in[7:0];
      if (reg_wr_in && reg_addr_in == OFS_VIS_PAGE) visibility_page_reg <= reg_wdata_in[7:0];
      if (reg_wr_in && reg_addr_in == OFS_CORE_CTRL) begin
        visibility_enable <= reg_wdata_in[VIS_ENABLE_BIT];
      end
      reg_rdata_out <= reg_rd_in ? next_rdata : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Address forming
  // ------------------------------------------------------------
  logic [15:0] ea_q;
  cmd_t        cmd_q;
  logic        bm_q;
  logic [15:0] wd_q;
  logic [1:0]  extra_cnt;
  logic [1:0]  next_extra;

  wire logic        idle;
  wire logic        table_busy;
  wire logic        is_table;
  wire logic [15:0] ea_sel;
  wire logic [23:0] form_addr;
  wire logic        form_config;
  wire logic        form_redirect;

  assign idle       = (state == ST_IDLE);
  assign table_busy = ~idle & (cmd_q != CMD_DATA_READ);
  assign ea_sel     = idle ? effective_address_in : ea_q;
  assign is_table   = idle ? (cmd_in != CMD_DATA_READ) : (cmd_q != CMD_DATA_READ);

  prog_addr_gen u_addr (
    .effective_address_in (ea_sel),
    .table_page_in        (table_page_reg),
    .vis_page_in          (visibility_page_reg),
    .vis_enable_in        (visibility_enable),
    .table_busy_in        (table_busy),
    .is_table_in          (is_table),
    .prog_addr_out        (form_addr),
    .config_space_out     (form_config),
    .redirect_out         (form_redirect),
    .row_base_out         (row_base_out),
    .page_base_out        (page_base_out)
  );

  // A data access is taken only when it is redirected
  wire logic take_req;
  assign take_req     = idle & req_in & ((cmd_in != CMD_DATA_READ) | form_redirect);
  assign redirect_out = form_redirect & ~is_table;

  // Extra cycles per instruction class
  assign next_extra = ~in_repeat_in ? (is_move_in ? EXTRA_MOVE : EXTRA_OTHER)
                    : (repeat_edge_in ? EXTRA_REP_EDGE : EXTRA_REP_MID);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_req) begin
          if (cmd_in == CMD_TABLE_WRITE_LOW || cmd_in == CMD_TABLE_WRITE_HIGH) begin
            next_state = ST_WRITE;
          end else begin
            next_state = ST_FETCH;
          end
        end
      end
      ST_FETCH:   next_state = (cmd_q == CMD_DATA_READ) ? ST_FETCH2 : ST_CAPTURE;
      ST_FETCH2:  next_state = ST_CAPTURE;
      ST_CAPTURE: next_state = (cmd_q == CMD_DATA_READ && extra_cnt != 2'h0) ? ST_EXTRA
                               : ST_IDLE;
      ST_EXTRA:   next_state = (extra_cnt == 2'h1) ? ST_IDLE : ST_EXTRA;
      ST_WRITE:   next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  // State, request capture and extra-cycle count
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      ea_q        <= 16'h0000;
      cmd_q       <= CMD_TABLE_READ_LOW;
      bm_q        <= 1'b0;
      wd_q        <= 16'h0000;
      extra_cnt   <= 2'h0;
      last_config <= 1'b0;
    end else begin
      state <= next_state;
      if (take_req) begin
        ea_q        <= effective_address_in;
        cmd_q       <= cmd_in;
        bm_q        <= byte_mode_in;
        wd_q        <= wdata_in;
        extra_cnt   <= next_extra;
        last_config <= form_config;
      end else if (state == ST_EXTRA) begin
        extra_cnt <= extra_cnt - 2'h1;
      end
    end
  end

  // Read data and completion
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 16'h0000;
    end else if (state == ST_CAPTURE) begin
      rdata_out <= format_read(cmd_q, bm_q, ea_q[0], pm_rdata_in);
    end
  end

  assign done_out  = (next_state == ST_IDLE) & ~idle;
  assign stall_out = ~idle;

  // ------------------------------------------------------------
  // Program memory drive
  // ------------------------------------------------------------
  wire logic hi_wr;
  assign hi_wr          = (cmd_q == CMD_TABLE_WRITE_HIGH);
  assign pm_addr_out    = form_addr;
  assign pm_rd_out      = (state == ST_FETCH) | (state == ST_FETCH2);
  assign pm_wr_out      = (state == ST_WRITE);
  assign pm_wdata_out   = hi_wr ? {wd_q[7:0], 16'h0000}
                        : (bm_q ? {8'h00, wd_q[7:0], wd_q[7:0]} : {8'h00, wd_q});
  assign pm_byte_en_out = hi_wr ? 3'h4 : (bm_q ? (ea_q[0] ? 3'h2 : 3'h1) : 3'h3);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  property p_vis_two_fetch;
    (state == ST_FETCH && cmd_q == CMD_DATA_READ) |-> pm_rd_out ##1 pm_rd_out;
  endproperty
  a_vis_two_fetch: assert property (p_vis_two_fetch) else $error("one fetch only");

  property p_vis_addr;
    (pm_rd_out && cmd_q == CMD_DATA_READ)
      |-> pm_addr_out == {1'b0, visibility_page_reg, ea_q[14:0]};
  endproperty
  a_vis_addr: assert property (p_vis_addr) else $error("bad visibility address");

  property p_tbl_addr;
    (pm_rd_out && cmd_q != CMD_DATA_READ) |-> pm_addr_out == {table_page_reg, ea_q};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("bad table address");

  property p_no_redirect_busy;
    table_busy |-> !redirect_out;
  endproperty
  a_no_redirect_busy: assert property (p_no_redirect_busy) else $error("redirect in table op");

  property p_redirect_cause;
    redirect_out |-> ea_sel[15] && visibility_enable;
  endproperty
  a_redirect_cause: assert property (p_redirect_cause) else $error("redirect without cause");

  property p_low_word;
    (state == ST_CAPTURE && cmd_q == CMD_TABLE_READ_LOW && !bm_q)
      |=> rdata_out == $past(pm_rdata_in[15:0]);
  endproperty
  a_low_word: assert property (p_low_word) else $error("low word wrong");

  property p_high_word;
    (state == ST_CAPTURE && cmd_q == CMD_TABLE_READ_HIGH && !bm_q)
      |=> rdata_out == {8'h00, $past(pm_rdata_in[23:16])};
  endproperty
  a_high_word: assert property (p_high_word) else $error("high word wrong");

  property p_move_extra;
    (take_req && cmd_in == CMD_DATA_READ && !in_repeat_in && is_move_in)
      |-> ##4 done_out;
  endproperty
  a_move_extra: assert property (p_move_extra) else $error("move stall wrong");

  property p_other_extra;
    (take_req && cmd_in == CMD_DATA_READ && !in_repeat_in && !is_move_in)
      |-> !done_out [*5] ##1 done_out;
  endproperty
  a_other_extra: assert property (p_other_extra) else $error("other stall wrong");

  property p_rep_mid;
    (take_req && cmd_in == CMD_DATA_READ && in_repeat_in && !repeat_edge_in)
      |-> ##3 done_out;
  endproperty
  a_rep_mid: assert property (p_rep_mid) else $error("repeat mid stall wrong");

  c_vis_read:   cover property (take_req && cmd_in == CMD_DATA_READ);
  c_tbl_low:    cover property (take_req && cmd_in == CMD_TABLE_READ_LOW && byte_mode_in);
  c_tbl_high:   cover property (take_req && cmd_in == CMD_TABLE_READ_HIGH);
  c_tbl_write:  cover property (pm_wr_out);

endmodule
`default_nettype wire

// *** prog_mem_model.sv ***
// Program memory partner for the program-space access bench.
// Assumes one-cycle read strobes answered on the following cycle.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic        sys_clk_in,   // Instruction clock
  input  wire logic [23:0] pm_addr_in,   // Program address
  input  wire logic        pm_rd_in,     // Read strobe
  output logic      [23:0] pm_rdata_out  // Word, cycle after strobe
);
  // Words from the whole program address, bit 0 included; user words hold 00 or FF upper bytes
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[23] ? (a[23:16] ^ a[8:1] ^ 8'h5A) : {8{a[1]}}, a[15:0] ^ 16'hC3A5};
  endfunction
  // Start from a non-zero pattern
  initial pm_rdata_out = 24'hA5A5A5;
  // Answer a strobe next cycle, otherwise keep toggling so stale data never passes
  always @(posedge sys_clk_in) begin
    if (pm_rd_in)
      pm_rdata_out <= word_at(pm_addr_in);
    else
      pm_rdata_out <= ~pm_rdata_out;
  end
endmodule
`default_nettype wire

// *** program_space_data_access_bench.sv ***
// Self-checking bench for the program-space data access block.
// Assumes the memory partner answers reads on the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module program_space_data_access_bench;
  import psv_pkg::*;
  // ------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------
  logic        sys_clk_in, nrst_in, reg_wr_in, reg_rd_in, req_in, byte_mode_in;
  logic        is_move_in, in_repeat_in, repeat_edge_in, redirect_out, stall_out;
  logic        done_out, pm_rd_out, pm_wr_out, addr_chk;
  logic [3:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, effective_address_in, wdata_in, reg_rdata_out, rdata_out;
  logic [23:0] row_base_out, page_base_out, pm_addr_out, pm_rdata_in, pm_wdata_out;
  logic [23:0] exp_pa, w;
  logic [2:0]  pm_byte_en_out, cls;
  logic [15:0] lf, ea;
  logic [7:0]  tbl, vis;
  cmd_t        cmd_in;
  int          n_fail, n_compared;
  localparam logic [2:0] VCLS [4] = '{3'h4, 3'h0, 3'h3, 3'h6};
  localparam int         VEXT [4] = '{1, 2, 2, 0};

  psv_access u_dut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .req_in(req_in), .cmd_in(cmd_in),
    .byte_mode_in(byte_mode_in), .effective_address_in(effective_address_in),
    .wdata_in(wdata_in), .is_move_in(is_move_in), .in_repeat_in(in_repeat_in),
    .repeat_edge_in(repeat_edge_in), .redirect_out(redirect_out), .stall_out(stall_out),
    .done_out(done_out), .rdata_out(rdata_out), .row_base_out(row_base_out),
    .page_base_out(page_base_out), .pm_addr_out(pm_addr_out), .pm_rd_out(pm_rd_out),
    .pm_rdata_in(pm_rdata_in), .pm_wr_out(pm_wr_out), .pm_wdata_out(pm_wdata_out),
    .pm_byte_en_out(pm_byte_en_out));
  prog_mem_model u_mem (.sys_clk_in(sys_clk_in), .pm_addr_in(pm_addr_out),
                        .pm_rd_in(pm_rd_out), .pm_rdata_out(pm_rdata_in));

  // ------------------------------------------------------------
  // Reference model and helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[23] ? (a[23:16] ^ a[8:1] ^ 8'h5A) : {8{a[1]}}, a[15:0] ^ 16'hC3A5};
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata_out});
  endtask
  // One core access: latency, address bases, write lanes or read data
  task automatic access(input cmd_t c, input logic bm, input int el, input logic [15:0] ed);
    int          lat;
    logic        wr;
    logic [15:0] msk;
    wr  = (c == CMD_TABLE_WRITE_LOW || c == CMD_TABLE_WRITE_HIGH);
    msk = bm ? 16'h00FF : 16'hFFFF;
    @(posedge sys_clk_in);
    req_in               <= 1'b1;
    cmd_in               <= c;
    byte_mode_in         <= bm;
    effective_address_in <= ea;
    wdata_in             <= ~ea;
    {is_move_in, in_repeat_in, repeat_edge_in} <= cls;
    addr_chk = !wr;
    @(posedge sys_clk_in);
    req_in <= 1'b0;
    if (c == CMD_TABLE_READ_LOW || c == CMD_TABLE_READ_HIGH)
      cmd_in <= CMD_DATA_READ;
    #1;
    lat = 1;
    while (done_out !== 1'b1 && lat < 20) begin
      if (c != CMD_DATA_READ)
        chk("redirect", 24'h0, {23'h0, redirect_out});
      @(posedge sys_clk_in);
      #1;
      lat++;
    end
    chk("latency", 24'(el), 24'(lat));
    chk("stall", 24'h1, {23'h0, stall_out});
    if (c != CMD_DATA_READ) begin
      chk("row_base", exp_pa & 24'hFFFF80, row_base_out);
      chk("page_base", exp_pa & 24'hFFFC00, page_base_out);
    end
    if (wr) begin
      chk("pm_wr", 24'h1, {23'h0, pm_wr_out});
      chk("pm_addr", exp_pa, pm_addr_out);
      if (c == CMD_TABLE_WRITE_LOW)
        chk("byte_en", {21'h0, bm ? {1'b0, ea[0], !ea[0]} : 3'h3}, {21'h0, pm_byte_en_out});
      else if (!(bm && ea[0]))
        chk("byte_en", 24'h4, {21'h0, pm_byte_en_out});
      if (!bm && c == CMD_TABLE_WRITE_LOW)
        chk("pm_wdata", {8'h00, ~ea}, {8'h00, pm_wdata_out[15:0]});
      else if (!bm)
        chk("pm_wdata", {16'h0000, ~ea[7:0]}, {16'h0000, pm_wdata_out[23:16]});
    end else begin
      @(posedge sys_clk_in);
      #1;
      chk("rdata", {8'h00, ed & msk}, {8'h00, rdata_out & msk});
    end
  endtask
  // Redirect decision for an address; a refused request must not stall
  task automatic probe(input logic [15:0] a, input logic e);
    @(posedge sys_clk_in);
    cmd_in               <= CMD_DATA_READ;
    effective_address_in <= a;
    req_in               <= !e;
    #1;
    chk("redirect", {23'h0, e}, {23'h0, redirect_out});
    @(posedge sys_clk_in);
    req_in <= 1'b0;
    #1;
    chk("stall", 24'h0, {23'h0, stall_out});
    chk("reg_idle", 24'h0, {8'h00, reg_rdata_out});
  endtask

  // ------------------------------------------------------------
  // First program fetch address of each read
  // ------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (addr_chk && pm_rd_out === 1'b1) begin
      chk("pm_addr", exp_pa, pm_addr_out);
      addr_chk = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #1000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, req_in, byte_mode_in, addr_chk} = '0;
    {reg_addr_in, reg_wdata_in, effective_address_in, wdata_in, cls} = '0;
    cmd_in = CMD_TABLE_READ_LOW;
    lf     = 16'hEC46;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    for (int r = 0; r < 4; r++)
      reg_rd(4'(r), 16'h0000);
    reg_wr(4'hA, 16'hFFFF);
    reg_rd(4'hA, 16'h0000);
    reg_wr(OFS_CORE_CTRL, 16'hFFFF);
    reg_rd(OFS_CORE_CTRL, 16'h0004);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      lf = step(lf);
      tbl = lf[7:0];
      reg_wr(OFS_TABLE_PAGE, {8'h00, tbl});
      lf = step(lf);
      ea = lf;
      exp_pa = {tbl, ea};
      w = word_at(exp_pa);
      access(CMD_TABLE_READ_LOW, 1'b0, 2, w[15:0]);
      access(CMD_TABLE_READ_LOW, 1'b1, 2, {8'h00, ea[0] ? w[15:8] : w[7:0]});
      access(CMD_TABLE_READ_HIGH, 1'b0, 2, {8'h00, w[23:16]});
      access(CMD_TABLE_READ_HIGH, 1'b1, 2, {8'h00, ea[0] ? 8'h00 : w[23:16]});
      access(CMD_TABLE_WRITE_LOW, i[0], 1, 16'h0000);
      access(CMD_TABLE_WRITE_HIGH, i[1], 1, 16'h0000);
      reg_rd(OFS_STATUS, {8'h00, tbl[7], 7'h00});
    end
    $display("table test done");
    for (int k = 0; k < 4; k++) begin
      lf = step(lf);
      vis = lf[15:8];
      reg_wr(OFS_VIS_PAGE, {8'h00, vis});
      ea = (k == 0) ? 16'h8000 : {1'b1, lf[14:0]};
      exp_pa = {1'b0, vis, ea[14:0]};
      w = word_at(exp_pa);
      cls = VCLS[k];
      access(CMD_DATA_READ, 1'b0, 3 + VEXT[k], w[15:0]);
    end
    probe(16'h7FFF, 1'b0);
    probe(16'h8000, 1'b1);
    reg_wr(OFS_CORE_CTRL, 16'hFFFB);
    probe(16'hFFFE, 1'b0);
    $display("visibility test done");
    wrap_up();
  end
endmodule
`default_nettype wire
